// ### design/lane_a_config.sv
// Notes on behaviour
// - bits 15:12 read zero, writes dropped
// - clock compensation is local or global bit
// - pin shows level, comma, lost, pass
// - pin select is local or global code
// - signal-lost detect needs local and global
// - upper config bit is local or global
// - upper config bit frozen while strap high
// - lower config bit is local or global
// - lower config bit frozen while strap high
// - upper emphasis is local or global
// - lower emphasis is local or global
// - loopback is local or mode bit
// - loopback bit frozen while pin high
// - pattern test is local or global
// - pattern bit frozen while pin high
// - alignment needs local, pin and global
// - power-down is local or mode bit
// - global write overwrites this lane register
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module lane_a_config (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // register bus
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // neighbouring registers, same clock
  input  wire logic [15:0] i_global_cfg,
  input  wire logic        i_global_write,
  input  wire logic [15:0] i_mode_ctrl,
  input  wire logic [7:0]  i_link_status,
  input  wire logic        i_hstl_mode,
  input  wire logic        i_comma_detected,
  // strap pins, asynchronous
  input  wire logic        i_cfg_pin_one,
  input  wire logic        i_cfg_pin_zero,
  input  wire logic        i_loopback_pin_a,
  input  wire logic        i_pattern_test_pin,
  input  wire logic        i_align_enable_pin,
  // effective lane controls
  output logic             o_multifunction_pin_a,
  output logic             o_ctc_enable,
  output logic             o_signal_lost_detect,
  output logic             o_cfg_bit_one,
  output logic             o_cfg_bit_zero,
  output logic             o_emphasis_upper,
  output logic             o_emphasis_lower,
  output logic             o_loopback,
  output logic             o_pattern_test,
  output logic             o_align_enable,
  output logic             o_power_down
);
  logic [11:0] lane, next_lane;   // stored lane bits
  logic [11:0] eff, next_eff;     // effective controls, lane layout
  logic        mf_pin, next_mf_pin;
  logic [4:0]  pins_raw;          // straps before crossing
  logic [4:0]  pins;              // straps after two stages
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic [1:0]  mf_sel;            // combined pin source code

  // strap order matches the pin positions in the package
  assign pins_raw = {i_align_enable_pin, i_pattern_test_pin,
                     i_loopback_pin_a, i_cfg_pin_zero,
                     i_cfg_pin_one};

  // straps come from pins, so they cross in before use
  pin_sync #(
    .WIDTH (lane_cfg_pkg::PIN_W)
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async (pins_raw),
    .o_sync  (pins)
  );

  // bus protocol lives in its own slave
  axil_slave u_bus (
    .i_clock   (i_clock),
    .i_rst_b   (i_rst_b),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_awaddr  (i_awaddr),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .o_bresp   (o_bresp),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .i_araddr  (i_araddr),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_ok   (wr_ok),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_ok   (rd_ok)
  );

  // only the lane register is writable; status is read-only
  assign wr_ok = (wr_addr == lane_cfg_pkg::ADDR_LANE_A);

  // read decode; upper bits padded with zero
  always_comb begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    case (rd_addr)
      lane_cfg_pkg::ADDR_LANE_A: rd_data = {20'h0, lane};
      lane_cfg_pkg::ADDR_STATUS: rd_data = {11'h0, pins, 3'h0, mf_pin, eff};
      default: rd_ok = 1'b0;
    endcase
  end

  // lane register next value: bus write, then global copy, then strap freeze
  always_comb begin
    next_lane = lane;
    if (wr_en && wr_ok) begin
      // reserved top nibble has no storage, so it is dropped
      if (wr_strb[0]) next_lane[7:0] = wr_data[7:0];
      if (wr_strb[1]) next_lane[11:8] = wr_data[11:8];
    end
    // global wins over a bus write in the same cycle
    if (i_global_write) begin
      next_lane = i_global_cfg[11:0] & lane_cfg_pkg::GLOBAL_COPY;
    end
    // a high strap holds the bit against every writer
    if (pins[lane_cfg_pkg::PIN_CFG_ONE]) begin
      next_lane[lane_cfg_pkg::BIT_CFG_ONE] = lane[lane_cfg_pkg::BIT_CFG_ONE];
    end
    if (pins[lane_cfg_pkg::PIN_CFG_ZERO]) begin
      next_lane[lane_cfg_pkg::BIT_CFG_ZERO] = lane[lane_cfg_pkg::BIT_CFG_ZERO];
    end
    if (pins[lane_cfg_pkg::PIN_LOOP]) begin
      next_lane[lane_cfg_pkg::BIT_LOOP] = lane[lane_cfg_pkg::BIT_LOOP];
    end
    if (pins[lane_cfg_pkg::PIN_PATTERN]) begin
      next_lane[lane_cfg_pkg::BIT_PATTERN] = lane[lane_cfg_pkg::BIT_PATTERN];
    end
  end

  assign mf_sel = lane[10:9] | i_global_cfg[10:9];

  // effective controls, combined with global and mode bits
  always_comb begin
    next_eff = lane | i_global_cfg[11:0];
    next_eff[10:9] = mf_sel;
    next_eff[lane_cfg_pkg::BIT_LOS] = lane[lane_cfg_pkg::BIT_LOS]
                                      & i_global_cfg[lane_cfg_pkg::BIT_LOS];
    next_eff[lane_cfg_pkg::BIT_LOOP] = lane[lane_cfg_pkg::BIT_LOOP]
                                       | i_mode_ctrl[lane_cfg_pkg::BIT_MODE_LOOP];
    next_eff[lane_cfg_pkg::BIT_ALIGN] = lane[lane_cfg_pkg::BIT_ALIGN]
                                        & pins[lane_cfg_pkg::PIN_ALIGN]
                                        & i_global_cfg[lane_cfg_pkg::BIT_ALIGN];
    next_eff[lane_cfg_pkg::BIT_PDOWN] = lane[lane_cfg_pkg::BIT_PDOWN]
                                        | i_mode_ctrl[lane_cfg_pkg::BIT_MODE_PDOWN];
  end

  // multifunction pin source
  always_comb begin
    case (mf_sel)
      lane_cfg_pkg::MF_IO_LEVEL: next_mf_pin = i_hstl_mode;
      lane_cfg_pkg::MF_COMMA:    next_mf_pin = i_comma_detected;
      lane_cfg_pkg::MF_LOST:     next_mf_pin = i_link_status[lane_cfg_pkg::BIT_STAT_LOST];
      lane_cfg_pkg::MF_PASS:     next_mf_pin = i_link_status[lane_cfg_pkg::BIT_STAT_PASS];
      default:                   next_mf_pin = 1'b0;
    endcase
  end

  // state registers; reset restores documented defaults
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      lane   <= lane_cfg_pkg::LANE_RESET;
      eff    <= lane_cfg_pkg::LANE_RESET;
      mf_pin <= 1'b0;
    end else begin
      lane   <= next_lane;
      eff    <= next_eff;
      mf_pin <= next_mf_pin;
    end
  end

  // outputs straight from the effective register and the multifunction pin register
  assign o_multifunction_pin_a = mf_pin;
  assign o_ctc_enable          = eff[lane_cfg_pkg::BIT_CTC];
  assign o_signal_lost_detect  = eff[lane_cfg_pkg::BIT_LOS];
  assign o_cfg_bit_one         = eff[lane_cfg_pkg::BIT_CFG_ONE];
  assign o_cfg_bit_zero        = eff[lane_cfg_pkg::BIT_CFG_ZERO];
  assign o_emphasis_upper      = eff[lane_cfg_pkg::BIT_EMPH_UP];
  assign o_emphasis_lower      = eff[lane_cfg_pkg::BIT_EMPH_LO];
  assign o_loopback            = eff[lane_cfg_pkg::BIT_LOOP];
  assign o_pattern_test        = eff[lane_cfg_pkg::BIT_PATTERN];
  assign o_align_enable        = eff[lane_cfg_pkg::BIT_ALIGN];
  assign o_power_down          = eff[lane_cfg_pkg::BIT_PDOWN];

  // checks on the stored and effective values
  a_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (o_rvalid && !$past(o_rvalid) && $past(rd_addr) == lane_cfg_pkg::ADDR_LANE_A)
    |-> o_rdata[31:12] == 20'h0)
    else $error("reserved lane bits read nonzero");

  a_ctc_or: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $past(i_rst_b) |-> o_ctc_enable == ($past(lane[11]) | $past(i_global_cfg[11])))
    else $error("clock compensation enable is wrong");

  a_mf_source: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    ($past(i_rst_b) && $past(mf_sel) == lane_cfg_pkg::MF_LOST)
    |-> o_multifunction_pin_a == $past(i_link_status[0]))
    else $error("multifunction pin not showing signal lost");

  a_mf_select: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $past(i_rst_b) |-> eff[10:9] == ($past(lane[10:9]) | $past(i_global_cfg[10:9])))
    else $error("pin select code is not combined");

  a_lost_and: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $past(i_rst_b) |-> o_signal_lost_detect == ($past(lane[8]) & $past(i_global_cfg[8])))
    else $error("signal lost detect is not the and");

  a_cfg_one_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    pins[lane_cfg_pkg::PIN_CFG_ONE] |=> $stable(lane[7]))
    else $error("upper config bit changed under strap");

  a_cfg_zero_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    pins[lane_cfg_pkg::PIN_CFG_ZERO] |=> $stable(lane[6]))
    else $error("lower config bit changed under strap");

  a_loop_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    pins[lane_cfg_pkg::PIN_LOOP] |=> $stable(lane[3]))
    else $error("loopback bit changed under pin");

  a_pattern_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    pins[lane_cfg_pkg::PIN_PATTERN] |=> $stable(lane[2]))
    else $error("pattern bit changed under pin");

  a_loop_or: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $past(i_rst_b) |-> o_loopback == ($past(lane[3]) | $past(i_mode_ctrl[14])))
    else $error("loopback is not the or");

  a_align_and: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    ($past(i_rst_b) && !$past(pins[lane_cfg_pkg::PIN_ALIGN])) |-> !o_align_enable)
    else $error("alignment enabled with pin low");

  a_pdown_or: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    ($past(i_rst_b) && $past(i_mode_ctrl[11])) |-> o_power_down)
    else $error("power down missed from mode bit");

  a_global_copy: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_global_write |=> lane[11:8] == $past(i_global_cfg[11:8]) && !lane[0])
    else $error("global write did not overwrite lane");

  a_write_lands: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (wr_en && wr_ok && wr_strb[1] && !i_global_write)
    |=> lane[11] == $past(wr_data[11]) ##1 o_ctc_enable == ($past(lane[11]) | $past(i_global_cfg[11])))
    else $error("bus write did not land");

  a_reset_value: assert property (@(posedge i_clock)
    !i_rst_b |=> lane == lane_cfg_pkg::LANE_RESET)
    else $error("lane register not at default after reset");
endmodule : lane_a_config

// ### design/lane_cfg_pkg.sv
package lane_cfg_pkg;
  // bus geometry
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned LANE_W = 12;   // stored bits 11:0, 15:12 reserved
  localparam int unsigned PIN_W  = 5;    // strap pins through the synchroniser

  // register indices, byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_LANE_A  = 8'h11;
  localparam logic [ADDR_W-1:0] IDX_STATUS  = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_LANE_A = {IDX_LANE_A[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'h0};

  // lane register field positions (global register shares them)
  localparam int BIT_CTC      = 11;
  localparam int BIT_MF_HI    = 10;
  localparam int BIT_MF_LO    = 9;
  localparam int BIT_LOS      = 8;
  localparam int BIT_CFG_ONE  = 7;
  localparam int BIT_CFG_ZERO = 6;
  localparam int BIT_EMPH_UP  = 5;
  localparam int BIT_EMPH_LO  = 4;
  localparam int BIT_LOOP     = 3;
  localparam int BIT_PATTERN  = 2;
  localparam int BIT_ALIGN    = 1;
  localparam int BIT_PDOWN    = 0;

  // positions in the mode register and the link status register
  localparam int BIT_MODE_LOOP  = 14;
  localparam int BIT_MODE_PDOWN = 11;
  localparam int BIT_STAT_LOST  = 0;
  localparam int BIT_STAT_PASS  = 4;

  // synchronised strap pin positions
  localparam int PIN_CFG_ONE  = 0;
  localparam int PIN_CFG_ZERO = 1;
  localparam int PIN_LOOP     = 2;
  localparam int PIN_PATTERN  = 3;
  localparam int PIN_ALIGN    = 4;

  // values after reset and copy mask for a global write
  localparam logic [LANE_W-1:0] LANE_RESET  = 12'h102;
  localparam logic [LANE_W-1:0] GLOBAL_COPY = 12'hff6;

  // multifunction pin source codes
  localparam logic [1:0] MF_IO_LEVEL = 2'h0;
  localparam logic [1:0] MF_COMMA    = 2'h1;
  localparam logic [1:0] MF_LOST     = 2'h2;
  localparam logic [1:0] MF_PASS     = 2'h3;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lane_cfg_pkg

// ### design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;     // first stage, read only by the second
  logic [WIDTH-1:0] stable;   // second stage

  initial begin
    if (WIDTH < 1) $error("pin_sync width must be at least one");
  end

  // two stages against metastability on pin inputs
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      meta   <= '0;
      stable <= '0;
    end else begin
      meta   <= i_async;
      stable <= meta;
    end
  end

  assign o_sync = stable;
endmodule : pin_sync

// ### design/axil_slave.sv
`timescale 1ns/1ps
module axil_slave (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_wr_en,
  output logic [7:0]       o_wr_addr,
  output logic [31:0]      o_wr_data,
  output logic [3:0]       o_wr_strb,
  input  wire logic        i_wr_ok,
  output logic [7:0]       o_rd_addr,
  input  wire logic [31:0] i_rd_data,
  input  wire logic        i_rd_ok
);
  typedef enum logic [1:0] {WR_IDLE, WR_GO, WR_RESP} wr_state_t;
  typedef enum logic [1:0] {RD_IDLE, RD_GO, RD_RESP} rd_state_t;

  wr_state_t   wr_state, next_wr_state;
  rd_state_t   rd_state, next_rd_state;
  logic        aw_have, next_aw_have;   // address caught
  logic        w_have,  next_w_have;    // data caught
  logic        awready, next_awready;
  logic        wready,  next_wready;
  logic        bvalid,  next_bvalid;
  logic [1:0]  bresp,   next_bresp;
  logic [7:0]  waddr,   next_waddr;
  logic [31:0] wdata,   next_wdata;
  logic [3:0]  wstrb,   next_wstrb;
  logic        arready, next_arready;
  logic        rvalid,  next_rvalid;
  logic [31:0] rdata,   next_rdata;
  logic [1:0]  rresp,   next_rresp;
  logic [7:0]  raddr,   next_raddr;

  // write side: address and data in either order, then one store cycle
  always_comb begin
    next_wr_state = wr_state;
    next_aw_have  = aw_have;
    next_w_have   = w_have;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_waddr    = waddr;
    next_wdata    = wdata;
    next_wstrb    = wstrb;
    case (wr_state)
      WR_IDLE: begin
        if (i_awvalid && awready) begin
          next_aw_have = 1'b1;
          next_waddr   = i_awaddr;
        end
        if (i_wvalid && wready) begin
          next_w_have = 1'b1;
          next_wdata  = i_wdata;
          next_wstrb  = i_wstrb;
        end
        if (next_aw_have && next_w_have) next_wr_state = WR_GO;
      end
      WR_GO: begin
        // store happens on this edge, answer follows
        next_wr_state = WR_RESP;
        next_bvalid   = 1'b1;
        next_bresp    = i_wr_ok ? lane_cfg_pkg::RESP_OKAY : lane_cfg_pkg::RESP_SLVERR;
        next_aw_have  = 1'b0;
        next_w_have   = 1'b0;
      end
      WR_RESP: begin
        if (i_bready) begin
          next_bvalid   = 1'b0;
          next_wr_state = WR_IDLE;
        end
      end
      default: next_wr_state = WR_IDLE;
    endcase
    next_awready = (next_wr_state == WR_IDLE) && !next_aw_have;
    next_wready  = (next_wr_state == WR_IDLE) && !next_w_have;
  end

  // read side: decode address a cycle, then hold data until taken
  always_comb begin
    next_rd_state = rd_state;
    next_rvalid   = rvalid;
    next_rdata    = rdata;
    next_rresp    = rresp;
    next_raddr    = raddr;
    case (rd_state)
      RD_IDLE: begin
        if (i_arvalid && arready) begin
          next_raddr    = i_araddr;
          next_rd_state = RD_GO;
        end
      end
      RD_GO: begin
        next_rvalid   = 1'b1;
        next_rdata    = i_rd_data;
        next_rresp    = i_rd_ok ? lane_cfg_pkg::RESP_OKAY : lane_cfg_pkg::RESP_SLVERR;
        next_rd_state = RD_RESP;
      end
      RD_RESP: begin
        if (i_rready) begin
          next_rvalid   = 1'b0;
          next_rd_state = RD_IDLE;
        end
      end
      default: next_rd_state = RD_IDLE;
    endcase
    next_arready = (next_rd_state == RD_IDLE);
  end

  // registers of both channels
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wr_state <= WR_IDLE;
      rd_state <= RD_IDLE;
      aw_have  <= 1'b0;
      w_have   <= 1'b0;
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= lane_cfg_pkg::RESP_OKAY;
      waddr    <= 8'h00;
      wdata    <= 32'h0;
      wstrb    <= 4'h0;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= 32'h0;
      rresp    <= lane_cfg_pkg::RESP_OKAY;
      raddr    <= 8'h00;
    end else begin
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
      aw_have  <= next_aw_have;
      w_have   <= next_w_have;
      awready  <= next_awready;
      wready   <= next_wready;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      waddr    <= next_waddr;
      wdata    <= next_wdata;
      wstrb    <= next_wstrb;
      arready  <= next_arready;
      rvalid   <= next_rvalid;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
      raddr    <= next_raddr;
    end
  end

  assign o_awready = awready;
  assign o_wready  = wready;
  assign o_bvalid  = bvalid;
  assign o_bresp   = bresp;
  assign o_arready = arready;
  assign o_rvalid  = rvalid;
  assign o_rdata   = rdata;
  assign o_rresp   = rresp;
  assign o_wr_en   = (wr_state == WR_GO);
  assign o_wr_addr = waddr;
  assign o_wr_data = wdata;
  assign o_wr_strb = wstrb;
  assign o_rd_addr = raddr;
endmodule : axil_slave

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  // one compare, counted, reported at once
  `define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin bad_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, sn); end end
  typedef struct {logic [31:0] wd; logic [11:0] g; logic [15:0] m; logic [11:0] rb;} row_t;
  localparam logic [7:0] LANE = lane_cfg_pkg::ADDR_LANE_A;
  logic        i_clock = 1'b0, i_rst_b = 1'b0;            // reset held from time zero
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00, i_link_status = 8'h01;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0]  i_wstrb = 4'hf;
  logic [15:0] i_global_cfg = 16'h0102, i_mode_ctrl = 16'h0;
  logic        i_global_write = 1'b0, i_hstl_mode = 1'b1, i_comma_detected = 1'b0, i_align_enable_pin = 1'b1;
  logic        i_cfg_pin_one = 1'b0, i_cfg_pin_zero = 1'b0, i_loopback_pin_a = 1'b0, i_pattern_test_pin = 1'b0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp, resp;
  logic [31:0] o_rdata, rdat;
  logic        o_multifunction_pin_a, o_ctc_enable, o_signal_lost_detect, o_cfg_bit_one, o_cfg_bit_zero;
  logic        o_emphasis_upper, o_emphasis_lower, o_loopback, o_pattern_test, o_align_enable, o_power_down;
  logic [10:0] seen;                                       // effective controls in one vector
  int          bad_count = 0, total_checks = 0;
  // ordinary cases: write value, global bits, mode bits, expected read-back
  row_t rows [5] = '{'{32'hffff_f000, 12'h000, 16'h0000, 12'h000}, '{32'h0000_0a55, 12'h102, 16'h0000, 12'ha55},
                     '{32'h0000_05aa, 12'h000, 16'h4800, 12'h5aa}, '{32'h0000_0fff, 12'hfff, 16'h0000, 12'hfff},
                     '{32'h0000_0200, 12'h400, 16'h4000, 12'h200}};
  assign seen = {o_ctc_enable, o_signal_lost_detect, o_cfg_bit_one, o_cfg_bit_zero, o_emphasis_upper,
                 o_emphasis_lower, o_loopback, o_pattern_test, o_align_enable, o_power_down, o_multifunction_pin_a};
  lane_a_config i_lane_a_config (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_global_cfg(i_global_cfg), .i_global_write(i_global_write), .i_mode_ctrl(i_mode_ctrl),
    .i_link_status(i_link_status), .i_hstl_mode(i_hstl_mode), .i_comma_detected(i_comma_detected),
    .i_cfg_pin_one(i_cfg_pin_one), .i_cfg_pin_zero(i_cfg_pin_zero), .i_loopback_pin_a(i_loopback_pin_a),
    .i_pattern_test_pin(i_pattern_test_pin), .i_align_enable_pin(i_align_enable_pin),
    .o_multifunction_pin_a(o_multifunction_pin_a), .o_ctc_enable(o_ctc_enable),
    .o_signal_lost_detect(o_signal_lost_detect), .o_cfg_bit_one(o_cfg_bit_one), .o_cfg_bit_zero(o_cfg_bit_zero),
    .o_emphasis_upper(o_emphasis_upper), .o_emphasis_lower(o_emphasis_lower), .o_loopback(o_loopback),
    .o_pattern_test(o_pattern_test), .o_align_enable(o_align_enable), .o_power_down(o_power_down));
  // 250 MHz clock
  always #2 i_clock = ~i_clock;
  // expected effective controls from stored, global and mode bits
  function automatic logic [10:0] eff(logic [11:0] l, logic [11:0] g, logic [15:0] m);
    logic [1:0] c;
    c = l[10:9] | g[10:9];
    return {l[11] | g[11], l[8] & g[8], l[7] | g[7], l[6] | g[6], l[5] | g[5], l[4] | g[4], l[3] | m[14],
            l[2] | g[2], l[1] & g[1] & i_align_enable_pin, l[0] | m[11],
            c == 2'h0 ? i_hstl_mode : c == 2'h1 ? i_comma_detected : c == 2'h2 ? i_link_status[0] : i_link_status[4]};
  endfunction : eff
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1);
    resp = o_bresp;
    i_bready <= 1'b0;
  endtask : wr
  // read: rready held until the answer is sampled
  task automatic rd(input logic [7:0] a);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (o_arready) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1);
    rdat = o_rdata;
    resp = o_rresp;
    i_rready <= 1'b0;
    #1;
  endtask : rd
  // the four freezing strap pins together, alignment pin left alone; two synchroniser flops plus margin
  task automatic straps(input logic v);
    {i_cfg_pin_one, i_cfg_pin_zero, i_loopback_pin_a, i_pattern_test_pin} <= {4{v}};
    repeat (3) @(posedge i_clock);
    #1;
  endtask : straps
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
    rd(LANE);
    `CHK("reset value", 32'h102, rdat)
    `CHK("reset controls", eff(12'h102, 12'h102, 16'h0), seen)
    $display("test reset finished");
    foreach (rows[k]) begin
      i_global_cfg <= {4'h0, rows[k].g};
      i_mode_ctrl <= rows[k].m;
      wr(LANE, rows[k].wd);
      `CHK("write resp", 2'h0, resp)
      rd(LANE);
      `CHK("read back", {20'h0, rows[k].rb}, rdat)
      `CHK("controls", eff(rows[k].rb, rows[k].g, rows[k].m), seen)
    end
    $display("test table finished");
    // global write copies into the lane register
    i_global_cfg <= 16'hffff;
    i_global_write <= 1'b1;
    @(posedge i_clock);
    i_global_write <= 1'b0;
    rd(LANE);
    `CHK("global copy", 32'hff6, rdat)
    $display("test global finished");
    // frozen bits resist both setting and clearing
    i_global_cfg <= 16'h0;
    wr(LANE, 32'h0);
    straps(1'b1);
    wr(LANE, 32'hfff);
    rd(LANE);
    `CHK("frozen set", 32'hf33, rdat)
    straps(1'b0);
    wr(LANE, 32'h0cc);
    straps(1'b1);
    wr(LANE, 32'h0);
    rd(LANE);
    `CHK("frozen clear", 32'h0cc, rdat)
    $display("test straps finished");
    // refused accesses, then a status read of the straps
    wr(lane_cfg_pkg::ADDR_STATUS, 32'hfff);
    `CHK("status write", 2'h2, resp)
    rd(8'hfc);
    `CHK("unmapped resp", 2'h2, resp)
    `CHK("unmapped data", 32'h0, rdat)
    rd(8'h45);
    `CHK("unaligned resp", 2'h2, resp)
    rd(lane_cfg_pkg::ADDR_STATUS);
    `CHK("status pins", 5'h1f, rdat[20:16])
    $display("test refused finished");
    // reset in mid-run restores defaults
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    rd(LANE);
    `CHK("second reset", 32'h102, rdat)
    $display("test rereset finished");
    complete_run();
  end
endmodule : tb
